// ### rtl/mic_consts.vh
// Purpose: Constants for the magnetometer interrupt and axis-enable block
// Assumes: 8-bit register port, byte offsets as the register map prints them
// Notes:   Every offset and every reset value but the status register's lives here, and every field position but the status threshold bits
`ifndef MIC_CONSTS_VH
`define MIC_CONSTS_VH

// Register offsets
`define MIC_ADDR_STATUS      8'h4a
`define MIC_ADDR_IRQ_EN      8'h4d
`define MIC_ADDR_PIN_AXIS    8'h4e
`define MIC_ADDR_LOW_THR     8'h4f
`define MIC_ADDR_HIGH_THR    8'h50

// Reset values
`define MIC_RST_IRQ_EN       8'h3f
`define MIC_RST_PIN_AXIS     8'h07
`define MIC_RST_LOW_THR      8'h00
`define MIC_RST_HIGH_THR     8'h00

// Interrupt enable fields
`define MIC_IE_OVERRUN       7
`define MIC_IE_OVERFLOW      6
`define MIC_IE_HIGH_LSB      3
`define MIC_IE_LOW_LSB       0

// Pin and axis fields
`define MIC_PA_READY_EN      7
`define MIC_PA_INT_EN        6
`define MIC_PA_CHAN_Z        5
`define MIC_PA_CHAN_LSB      3
`define MIC_PA_READY_POL     2
`define MIC_PA_LATCH         1
`define MIC_PA_INT_POL       0

// Status fields
`define MIC_ST_OVERRUN       7
`define MIC_ST_OVERFLOW      6

`endif

// ### rtl/mic_axis_cmp.v
// Purpose: Per-axis threshold compare against the held axis value
// Assumes: Axis value is the signed top byte of the field data
// Notes:   Result is registered, one cycle after the done pulse
`timescale 1ns/1ns
`default_nettype none

module mic_axis_cmp #(
  parameter DATA_W = 13
) (
  input  wire              clk,
  input  wire              srst,
  input  wire              done,
  input  wire [DATA_W-1:0] value,
  input  wire [7:0]        lower_limit_value,
  input  wire [7:0]        upper_limit_value,
  output reg               below,
  output reg               above
);

  // Compare scale: top byte of the signed field word
  wire signed [7:0] top = value[DATA_W-1:DATA_W-8];

  // Evaluated once per finished measurement cycle
  always @(posedge clk) begin
    if (srst) begin
      below <= 1'b0;
      above <= 1'b0;
    end else if (done) begin
      below <= (top < $signed(lower_limit_value));
      above <= (top > $signed(upper_limit_value));
    end
  end

endmodule

`default_nettype wire

// ### rtl/mic_top.v
// Contract
// - Overrun flag reports only while overrun enable bit 7 is set; resets off.
// - Overflow enable bit 6 routes the overflow flag to the interrupt pin.
// - High-threshold enables z,y,x at bits 5..3, active low, reset 1.
// - Low-threshold enables z,y,x at bits 2..0, active low, reset 1.
// - A disabled channel keeps its last field value unchanged.
// - Disabled z channel stops resistance measurement; resistance output reads zero.
// - Threshold interrupts on disabled axes keep using the last value.
// - Ready pin shows data-ready only while ready pin enable is set.
// - Interrupt pin shows interrupt status only while interrupt pin enable set.
// - Channel enables z,y,x active low, reset 0; z also gates resistance.
// - Ready pin polarity bit: 0 active low, 1 active high, reset 1.
// - Interrupt pin polarity bit: 1 active high, 0 active low, reset 1.
// - Host-writable 8-bit low threshold register compares low interrupts.
// - Status register: overrun, overflow, high z,y,x, low z,y,x.
// - Host-writable 8-bit high threshold register compares high interrupts.
//
// Purpose: Magnetometer interrupt configuration, axis enables, pin mapping
// Assumes: Sensor core supplies raw axis data, done pulse and event pulses
// Notes:   Register port is a simple byte port with write and read strobes
`timescale 1ns/1ns
`default_nettype none
`include "mic_consts.vh"

module mic_top #(
  parameter DATA_W = 13,
  parameter RES_W  = 14
) (
  input  wire              clk,
  input  wire              srst,
  // Register port
  input  wire [7:0]        reg_addr,
  input  wire              reg_wr,
  input  wire              reg_rd,
  input  wire [7:0]        reg_wdata,
  output reg  [7:0]        reg_rdata,
  // Sensor core side
  input  wire              meas_done,
  input  wire [DATA_W-1:0] raw_x,
  input  wire [DATA_W-1:0] raw_y,
  input  wire [DATA_W-1:0] raw_z,
  input  wire [RES_W-1:0]  raw_res,
  input  wire              overrun_evt,
  input  wire              overflow_evt,
  input  wire              ready_set,
  // Held data, channel enables
  output reg  [DATA_W-1:0] data_x,
  output reg  [DATA_W-1:0] data_y,
  output reg  [DATA_W-1:0] data_z,
  output reg  [RES_W-1:0]  data_res,
  output reg  [2:0]        chan_run,
  output reg               res_run,
  // Pins
  output reg               sample_ready_pin,
  output reg               int_pin
);

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  reg [7:0] mag_irq_enable_ctrl;
  reg [7:0] mag_pin_axis_ctrl;
  reg [7:0] lower_limit_value;
  reg [7:0] upper_limit_value;
  reg [7:0] status;
  reg       ready_flag;
  reg       int_hold;
  reg       cmp_valid;

  wire [2:0] high_on = ~mag_irq_enable_ctrl[`MIC_IE_HIGH_LSB+2:`MIC_IE_HIGH_LSB];
  wire [2:0] low_on  = ~mag_irq_enable_ctrl[`MIC_IE_LOW_LSB+2:`MIC_IE_LOW_LSB];
  wire [2:0] chan_on = ~mag_pin_axis_ctrl[`MIC_PA_CHAN_LSB+2:`MIC_PA_CHAN_LSB];
  wire       st_read = reg_rd && (reg_addr == `MIC_ADDR_STATUS);

  // Host writes to the two control registers and both thresholds
  always @(posedge clk) begin
    if (srst) begin
      mag_irq_enable_ctrl <= `MIC_RST_IRQ_EN;
      mag_pin_axis_ctrl   <= `MIC_RST_PIN_AXIS;
      lower_limit_value   <= `MIC_RST_LOW_THR;
      upper_limit_value   <= `MIC_RST_HIGH_THR;
    end else if (reg_wr) begin
      case (reg_addr)
        `MIC_ADDR_IRQ_EN:   mag_irq_enable_ctrl <= reg_wdata;
        `MIC_ADDR_PIN_AXIS: mag_pin_axis_ctrl   <= reg_wdata;
        `MIC_ADDR_LOW_THR:  lower_limit_value   <= reg_wdata;
        `MIC_ADDR_HIGH_THR: upper_limit_value   <= reg_wdata;
        default: ;
      endcase
    end
  end

  // Registered read data; unmapped addresses read zero
  always @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        `MIC_ADDR_STATUS:   reg_rdata <= status;
        `MIC_ADDR_IRQ_EN:   reg_rdata <= mag_irq_enable_ctrl;
        `MIC_ADDR_PIN_AXIS: reg_rdata <= mag_pin_axis_ctrl;
        `MIC_ADDR_LOW_THR:  reg_rdata <= lower_limit_value;
        `MIC_ADDR_HIGH_THR: reg_rdata <= upper_limit_value;
        default:            reg_rdata <= 8'h00;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Measurement data hold

  // Disabled channels keep their last value; the core never overwrites them
  always @(posedge clk) begin
    if (srst) begin
      data_x   <= {DATA_W{1'b0}};
      data_y   <= {DATA_W{1'b0}};
      data_z   <= {DATA_W{1'b0}};
      data_res <= {RES_W{1'b0}};
      chan_run <= 3'h7;
      res_run  <= 1'b1;
    end else begin
      chan_run <= chan_on;
      res_run  <= chan_on[2];
      if (meas_done && chan_on[0]) data_x <= raw_x;
      if (meas_done && chan_on[1]) data_y <= raw_y;
      if (meas_done && chan_on[2]) data_z <= raw_z;
      if (!chan_on[2])
        data_res <= {RES_W{1'b0}};
      else if (meas_done)
        data_res <= raw_res;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Threshold compare, one instance per axis
  wire [DATA_W-1:0] held [0:2];
  wire [2:0]        below;
  wire [2:0]        above;
  assign held[0] = data_x;
  assign held[1] = data_y;
  assign held[2] = data_z;

  // Compares the held value, so disabled axes still use their last sample
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1) begin : g_axis
      mic_axis_cmp #(
        .DATA_W (DATA_W)
      ) u_cmp (
        .clk               (clk),
        .srst              (srst),
        .done              (cmp_valid),
        .value             (held[g]),
        .lower_limit_value (lower_limit_value),
        .upper_limit_value (upper_limit_value),
        .below             (below[g]),
        .above             (above[g])
      );
    end
  endgenerate

  // Compare strobe runs one cycle after data capture; result a cycle later
  reg res_valid;
  always @(posedge clk) begin
    if (srst) begin
      cmp_valid <= 1'b0;
      res_valid <= 1'b0;
    end else begin
      cmp_valid <= meas_done;
      res_valid <= cmp_valid;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Status flags: sticky, cleared by a status read; a new event wins
  wire [7:0] ev;
  assign ev[`MIC_ST_OVERRUN]  = overrun_evt && mag_irq_enable_ctrl[`MIC_IE_OVERRUN];
  assign ev[`MIC_ST_OVERFLOW] = overflow_evt;
  assign ev[5:3] = {3{res_valid}} & above & high_on;
  assign ev[2:0] = {3{res_valid}} & below & low_on;

  always @(posedge clk) begin
    if (srst) begin
      status <= 8'h00;
    end else begin
      status <= (st_read ? 8'h00 : status) | ev;
    end
  end

  // Condition seen by the pin: threshold flags plus overflow if routed
  wire cond = (|status[5:0] & ~status[`MIC_ST_OVERFLOW] & 1'b1) | (|status[5:0])
            | (status[`MIC_ST_OVERFLOW] & mag_irq_enable_ctrl[`MIC_IE_OVERFLOW]);
  wire ev_int = (|ev[5:0])
              | (ev[`MIC_ST_OVERFLOW] & mag_irq_enable_ctrl[`MIC_IE_OVERFLOW]);

  // Latched mode holds until a status read; a fresh event still wins
  always @(posedge clk) begin
    if (srst)
      int_hold <= 1'b0;
    else if (ev_int)
      int_hold <= 1'b1;
    else if (st_read)
      int_hold <= 1'b0;
  end

  // Data-ready flag, set by the core, cleared on a status read
  always @(posedge clk) begin
    if (srst)
      ready_flag <= 1'b0;
    else if (ready_set)
      ready_flag <= 1'b1;
    else if (st_read)
      ready_flag <= 1'b0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Output pins; disabled pins sit at their inactive level
  wire int_act = mag_pin_axis_ctrl[`MIC_PA_LATCH] ? int_hold : cond;
  wire int_lvl = mag_pin_axis_ctrl[`MIC_PA_INT_EN] & int_act;
  wire rdy_lvl = mag_pin_axis_ctrl[`MIC_PA_READY_EN] & ready_flag;

  always @(posedge clk) begin
    if (srst) begin
      int_pin          <= 1'b0;
      sample_ready_pin <= 1'b0;
    end else begin
      int_pin          <= ~(int_lvl ^ mag_pin_axis_ctrl[`MIC_PA_INT_POL]);
      sample_ready_pin <= ~(rdy_lvl ^ mag_pin_axis_ctrl[`MIC_PA_READY_POL]);
    end
  end

endmodule

`default_nettype wire

// ### dv/mic_top_chk.sv
// Purpose: Port-level checks for the interrupt and axis-enable block
// Assumes: Bound into every mic_top instance, one clock domain
// Notes:   Watches design outputs along with the bench-driven inputs behind them
`timescale 1ns/1ns
`default_nettype none
module mic_top_chk #(
  parameter DATA_W = 13,
  parameter RES_W  = 14
) (
  input wire logic              clk,
  input wire logic              srst,
  input wire logic [7:0]        reg_addr,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [7:0]        reg_wdata,
  input wire logic [7:0]        reg_rdata,
  input wire logic              meas_done,
  input wire logic [DATA_W-1:0] raw_x,
  input wire logic [RES_W-1:0]  raw_res,
  input wire logic [DATA_W-1:0] data_x,
  input wire logic [RES_W-1:0]  data_res,
  input wire logic [2:0]        chan_run,
  input wire logic              res_run
);
  // Single domain, so clock and reset are given once
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  ////////////////////////////////////////////////////////////////////////////
  // Held data only moves on a measurement of a running channel
  a_x_idle_hold: assert property (!meas_done |=> $stable(data_x))
    else $error("x data moved without a measurement");
  // Run flags lag the enable by a cycle, so the capture cycle's enable shows one cycle later
  a_x_frozen_off: assert property (meas_done ##1 !chan_run[0] |-> $stable(data_x))
    else $error("x data moved while x channel off");
  a_x_load_on: assert property (meas_done ##1 chan_run[0] |-> data_x == $past(raw_x))
    else $error("x data not loaded from measurement");
  // Resistance is tied to the z channel
  a_res_follow_z: assert property (res_run == chan_run[2])
    else $error("resistance run differs from z channel");
  a_res_zero_off: assert property (!res_run |-> data_res == '0)
    else $error("resistance not zero while stopped");
  a_res_load_on: assert property (meas_done ##1 res_run |-> data_res == $past(raw_res))
    else $error("resistance not loaded from measurement");
  // Register effects, checked back to back to catch a stale read path
  a_low_thr_back: assert property (reg_wr && reg_addr == 8'h4f ##1 reg_rd && reg_addr == 8'h4f
    |=> reg_rdata == $past(reg_wdata, 2))
    else $error("low limit readback wrong");
  // Register lands on the write edge, run flags follow one edge later
  a_chan_write: assert property (reg_wr && reg_addr == 8'h4e
    |-> ##2 chan_run == ~$past(reg_wdata[5:3], 2))
    else $error("channel run bits do not follow write");
endmodule
bind mic_top mic_top_chk #(.DATA_W(DATA_W), .RES_W(RES_W)) u_chk (
  .clk(clk), .srst(srst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .meas_done(meas_done), .raw_x(raw_x),
  .raw_res(raw_res), .data_x(data_x), .data_res(data_res), .chan_run(chan_run),
  .res_run(res_run));
`default_nettype wire

// ### dv/mic_core_model.sv
// Purpose: Sensor core stand-in feeding measurements and event pulses
// Assumes: Tasks are called just after a rising edge
// Notes:   Raw lines go stale after the done pulse to catch late sampling
`timescale 1ns/1ns
`default_nettype none
module mic_core_model #(
  parameter DATA_W = 13,
  parameter RES_W  = 14
) (
  input  wire logic              clk,
  output var  logic              meas_done,
  output var  logic [DATA_W-1:0] raw_x,
  output var  logic [DATA_W-1:0] raw_y,
  output var  logic [DATA_W-1:0] raw_z,
  output var  logic [RES_W-1:0]  raw_res,
  output var  logic              overrun_evt,
  output var  logic              overflow_evt,
  output var  logic              ready_set
);
  // Quiet at time zero
  initial begin
    {meas_done, overrun_evt, overflow_evt, ready_set} = 4'h0;
    {raw_x, raw_y, raw_z, raw_res} = '0;
  end
  // One measurement; two spare cycles keep the done spacing legal
  task automatic meas(input logic [DATA_W-1:0] x, y, z, input logic [RES_W-1:0] r);
    meas_done <= 1'b1;
    {raw_x, raw_y, raw_z, raw_res} <= {x, y, z, r};
    @(posedge clk);
    meas_done <= 1'b0;
    {raw_x, raw_y, raw_z, raw_res} <= ~{x, y, z, r};
    repeat (2) @(posedge clk);
  endtask
  // Event pulses as {overrun, overflow, ready}
  task automatic evt(input logic [2:0] sel);
    {overrun_evt, overflow_evt, ready_set} <= sel;
    @(posedge clk);
    {overrun_evt, overflow_evt, ready_set} <= 3'b000;
    repeat (2) @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_mic_top.sv
// Purpose: Directed bench for the interrupt and axis-enable block
// Assumes: Byte register port, core stand-in on the sensor side
// Notes:   Values are sampled only after they have settled
`timescale 1ns/1ns
`default_nettype none
module tb_mic_top;
  logic        clk, srst, reg_wr, reg_rd, meas_done, res_run;
  logic        overrun_evt, overflow_evt, ready_set, sample_ready_pin, int_pin;
  logic [7:0]  reg_addr, reg_wdata, reg_rdata;
  logic [12:0] raw_x, raw_y, raw_z, data_x, data_y, data_z;
  logic [13:0] raw_res, data_res;
  logic [2:0]  chan_run;
  int          failures = 0, n_checks = 0, cyc = 0;
  mic_top dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .meas_done(meas_done), .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z), .raw_res(raw_res),
    .overrun_evt(overrun_evt), .overflow_evt(overflow_evt), .ready_set(ready_set),
    .data_x(data_x), .data_y(data_y), .data_z(data_z), .data_res(data_res),
    .chan_run(chan_run), .res_run(res_run), .sample_ready_pin(sample_ready_pin),
    .int_pin(int_pin));
  mic_core_model core (.clk(clk), .meas_done(meas_done),
    .raw_x(raw_x), .raw_y(raw_y), .raw_z(raw_z), .raw_res(raw_res),
    .overrun_evt(overrun_evt), .overflow_evt(overflow_evt), .ready_set(ready_set));
  ////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // Wide enough for two held field words side by side
  task automatic chk(input logic [31:0] seen, exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One bus cycle; every strobe is assigned once per edge, so no double drive
  task automatic bus(input logic w, r, input logic [7:0] a, d);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, r, a, d};
    @(posedge clk);
  endtask
  task automatic idle(input int n);
    repeat (n) bus(1'b0, 1'b0, 8'h00, 8'h00);
  endtask
  task automatic wr(input logic [7:0] a, d);
    bus(1'b1, 1'b0, a, d);
    idle(2);
  endtask
  task automatic rd(input logic [7:0] a, exp);
    bus(1'b0, 1'b1, a, 8'h00);
    idle(1);
    chk(reg_rdata, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Hang guard, well above the directed run length
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      end_of_test();
    end
  end
  initial begin
    {srst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 16'h0000};
    repeat (6) @(posedge clk);
    srst <= 1'b0;
    @(posedge clk);
    rd(8'h4d, 8'h3f);
    rd(8'h4e, 8'h07);
    rd(8'h4f, 8'h00);
    rd(8'h4a, 8'h00);
    rd(8'h00, 8'h00);
    chk({res_run, chan_run, sample_ready_pin, int_pin}, 16'h003c);
    // Write then read back to back
    bus(1'b1, 1'b0, 8'h4f, 8'h10);
    bus(1'b0, 1'b1, 8'h4f, 8'h00);
    idle(1);
    chk(reg_rdata, 8'h10);
    wr(8'h4d, 8'h1e);
    wr(8'h4e, 8'h47);
    core.meas(13'h0040, 13'h0fff, 13'h0100, 14'h1234);
    idle(3);
    chk({data_x, data_res}, {13'h0040, 14'h1234});
    chk(data_z, 13'h0100);
    chk(int_pin, 1'b1);
    rd(8'h4a, 8'h21);
    idle(2);
    chk(int_pin, 1'b0);
    // X and z off: new values would clear both flags, old values set them
    wr(8'h4e, 8'h6f);
    chk({res_run, chan_run}, 16'h0002);
    core.meas(13'h0fff, 13'h0800, 13'h0000, 14'h0555);
    idle(3);
    chk({data_x, data_y}, {13'h0040, 13'h0800});
    chk(data_z, 13'h0100);
    chk(data_res, 14'h0000);
    rd(8'h4a, 8'h21);
    // Non-latched, active low
    wr(8'h4e, 8'h44);
    chk(int_pin, 1'b1);
    core.evt(3'b010);
    chk(int_pin, 1'b1);
    wr(8'h4d, 8'h5e);
    idle(1);
    chk(int_pin, 1'b0);
    rd(8'h4a, 8'h40);
    idle(2);
    chk(int_pin, 1'b1);
    core.evt(3'b100);
    rd(8'h4a, 8'h00);
    wr(8'h4d, 8'hde);
    core.evt(3'b100);
    rd(8'h4a, 8'h80);
    core.evt(3'b001);
    chk(sample_ready_pin, 1'b0);
    wr(8'h4e, 8'hc4);
    idle(1);
    chk(sample_ready_pin, 1'b1);
    wr(8'h4e, 8'hc0);
    idle(1);
    chk(sample_ready_pin, 1'b0);
    // High limit of its own; values equal to a limit set no flag
    wr(8'h50, 8'h08);
    rd(8'h50, 8'h08);
    core.meas(13'h0200, 13'h0000, 13'h0100, 14'h0001);
    idle(3);
    rd(8'h4a, 8'h00);
    // One step past each limit; x high stays off since its active-low enable bit 3 is set
    core.meas(13'h01e0, 13'h0000, 13'h0120, 14'h0001);
    idle(3);
    rd(8'h4a, 8'h21);
    end_of_test();
  end
endmodule
`default_nettype wire
